//--- design/panel_pkg.sv
package panel_pkg;

  // 10 MHz system clock
  localparam int unsigned CLK_HZ          = 10_000_000;
  // Display dwell in automatic cycling
  localparam int unsigned DWELL_MS        = 1000;
  localparam int unsigned DWELL_CYCLES    = CLK_HZ / 1000 * DWELL_MS;
  // Backlight inactivity timeout
  localparam int unsigned IDLE_S          = 60;
  localparam int unsigned IDLE_CYCLES     = CLK_HZ * IDLE_S;
  // Key debounce window
  localparam int unsigned DEBOUNCE_MS     = 10;
  localparam int unsigned DEBOUNCE_CYCLES = CLK_HZ / 1000 * DEBOUNCE_MS;

  localparam int unsigned NUM_KEYS        = 4;
  localparam int unsigned PARAM_W         = 4;
  localparam logic [3:0]  PARAM_LAST_RST  = 4'hF;
  localparam logic [3:0]  PARAM_RST       = 4'h0;

  // Index of each key in the key vector
  localparam int unsigned KEY_ENTER       = 0;
  localparam int unsigned KEY_UP          = 1;
  localparam int unsigned KEY_DOWN        = 2;
  localparam int unsigned KEY_ESC         = 3;

  typedef enum {MODE_CYCLE, MODE_HOLD} mode_t;

  typedef struct packed {
    logic esc;
    logic down;
    logic up;
    logic enter;
  } keys_t;

endpackage : panel_pkg

//--- design/key_debounce.sv
`timescale 1ns/1ps
`default_nettype none

// Synchronises one raw key, filters bounce, pulses once per press
module key_debounce #(
  parameter int unsigned STABLE_CYCLES = panel_pkg::DEBOUNCE_CYCLES
) (
  input  wire logic CLK,
  input  wire logic RESET,
  input  wire logic key_raw,
  output logic      press
);

  localparam int unsigned CW = $clog2(STABLE_CYCLES + 1);

  logic          sync_a;
  logic          sync_b;
  logic          stable;
  logic          next_stable;
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic          next_press;

  always_comb
  begin
    next_stable = stable;
    next_count  = count;
    next_press  = 1'b0;
    if (sync_b == stable)
      next_count = '0;
    else if (count == CW'(STABLE_CYCLES - 1))
    begin
      next_count  = '0;
      next_stable = sync_b;
      next_press  = sync_b;
    end
    else
      next_count = count + CW'(1);
  end

  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      stable <= 1'b0;
      count  <= '0;
      press  <= 1'b0;
    end
    else
    begin
      sync_a <= key_raw;
      sync_b <= sync_a;
      stable <= next_stable;
      count  <= next_count;
      press  <= next_press;
    end
  end

  AST_ONE_PULSE: assert property (@(posedge CLK) disable iff (RESET) press |=> !press)
    else $error("press pulse longer than one cycle");

endmodule : key_debounce

`default_nettype wire

//--- design/front_panel.sv
// Operation
// - Leaving reset, the backlight is on and the display cycles through all parameters.
// - In cycling mode each parameter stays about one second, then the next follows, wrapping.
// - In cycling mode only Enter changes the mode; Up, Down and Esc do not change the selection.
// - Enter in cycling mode freezes the shown parameter and enters hold mode.
// - In hold mode Up selects the next parameter and Down the previous one.
// - Esc in hold mode returns to cycling mode.
// - With the backlight on, one minute without a keypress switches it off.
// - With the backlight off, any key switches it back on.
`timescale 1ns/1ps
`default_nettype none

module front_panel #(
  parameter int unsigned DWELL_CYCLES    = panel_pkg::DWELL_CYCLES,
  parameter int unsigned IDLE_CYCLES     = panel_pkg::IDLE_CYCLES,
  parameter int unsigned DEBOUNCE_CYCLES = panel_pkg::DEBOUNCE_CYCLES
) (
  input  wire logic                         CLK,
  input  wire logic                         RESET,
  input  wire panel_pkg::keys_t             KEYS,
  input  wire logic [panel_pkg::PARAM_W-1:0] PARAM_LAST,
  output logic [panel_pkg::PARAM_W-1:0]     PARAM_SEL,
  output logic                              HOLD,
  output logic                              BACKLIGHT
);

  localparam int unsigned DW = $clog2(DWELL_CYCLES + 1);
  localparam int unsigned IW = $clog2(IDLE_CYCLES + 1);

  panel_pkg::keys_t               press;
  panel_pkg::mode_t               mode;
  panel_pkg::mode_t               next_mode;
  logic [panel_pkg::PARAM_W-1:0]  next_sel;
  logic [DW-1:0]                  dwell;
  logic [DW-1:0]                  next_dwell;
  logic [IW-1:0]                  idle;
  logic [IW-1:0]                  next_idle;
  logic                           next_light;
  logic                           any_press;

  genvar k;
  generate
    for (k = 0; k < panel_pkg::NUM_KEYS; k++)
    begin : g_key
      key_debounce #(
        .STABLE_CYCLES (DEBOUNCE_CYCLES)
      ) u_deb (
        .CLK     (CLK),
        .RESET   (RESET),
        .key_raw (KEYS[k]),
        .press   (press[k])
      );
    end
  endgenerate

  assign any_press = |press;

  // Mode and parameter selection
  always_comb
  begin
    next_mode  = mode;
    next_sel   = PARAM_SEL;
    next_dwell = dwell;
    case (mode)
      panel_pkg::MODE_CYCLE:
      begin
        // Up, Down, Esc ignored here
        if (press.enter)
        begin
          next_mode  = panel_pkg::MODE_HOLD;
          next_dwell = '0;
        end
        else if (dwell == DW'(DWELL_CYCLES - 1))
        begin
          next_dwell = '0;
          next_sel   = (PARAM_SEL >= PARAM_LAST) ? '0 : PARAM_SEL + 4'h1;
        end
        else
          next_dwell = dwell + DW'(1);
      end
      panel_pkg::MODE_HOLD:
      begin
        next_dwell = '0;
        if (press.esc)
          next_mode = panel_pkg::MODE_CYCLE;
        else if (press.up)
          next_sel = (PARAM_SEL >= PARAM_LAST) ? '0 : PARAM_SEL + 4'h1;
        else if (press.down)
          next_sel = (PARAM_SEL == '0) ? PARAM_LAST : PARAM_SEL - 4'h1;
      end
      default:
      begin
        next_mode  = panel_pkg::MODE_CYCLE;
        next_dwell = '0;
      end
    endcase
  end

  // Backlight and inactivity timer
  always_comb
  begin
    next_light = BACKLIGHT;
    next_idle  = idle;
    if (any_press)
    begin
      next_idle  = '0;
      next_light = 1'b1;
    end
    else if (BACKLIGHT)
    begin
      if (idle == IW'(IDLE_CYCLES - 1))
      begin
        next_light = 1'b0;
        next_idle  = '0;
      end
      else
        next_idle = idle + IW'(1);
    end
  end

  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      mode      <= panel_pkg::MODE_CYCLE;
      PARAM_SEL <= panel_pkg::PARAM_RST;
      dwell     <= '0;
      idle      <= '0;
      BACKLIGHT <= 1'b1;
    end
    else
    begin
      mode      <= next_mode;
      PARAM_SEL <= next_sel;
      dwell     <= next_dwell;
      idle      <= next_idle;
      BACKLIGHT <= next_light;
    end
  end

  assign HOLD = (mode == panel_pkg::MODE_HOLD);

  sequence s_cycle_no_enter;
    !HOLD && !press.enter;
  endsequence

  AST_CYCLE_ADVANCE: assert property (@(posedge CLK) disable iff (RESET)
    (!HOLD && !press.enter && dwell == DW'(DWELL_CYCLES - 1)) |=> ($changed(PARAM_SEL) || PARAM_LAST == '0))
    else $error("cycling did not advance after dwell");

  AST_CYCLE_STEADY: assert property (@(posedge CLK) disable iff (RESET)
    (s_cycle_no_enter and (dwell != DW'(DWELL_CYCLES - 1))) |=> $stable(PARAM_SEL))
    else $error("parameter changed before dwell ended");

  AST_CYCLE_IGNORES: assert property (@(posedge CLK) disable iff (RESET)
    (!HOLD && !press.enter && (press.up || press.down || press.esc)) |=> !HOLD)
    else $error("non-enter key changed mode in cycling");

  AST_ENTER_HOLDS: assert property (@(posedge CLK) disable iff (RESET)
    (!HOLD && press.enter) |=> (HOLD && $stable(PARAM_SEL)))
    else $error("enter did not freeze parameter");

  AST_HOLD_STILL: assert property (@(posedge CLK) disable iff (RESET)
    (HOLD && !press.up && !press.down && !press.esc) |=> $stable(PARAM_SEL))
    else $error("parameter moved in hold mode");

  AST_UP_STEP: assert property (@(posedge CLK) disable iff (RESET)
    (HOLD && press.up && !press.esc && PARAM_SEL < PARAM_LAST) |=> PARAM_SEL == $past(PARAM_SEL) + 4'h1)
    else $error("up did not select next parameter");

  AST_DOWN_STEP: assert property (@(posedge CLK) disable iff (RESET)
    (HOLD && press.down && !press.up && !press.esc && PARAM_SEL != '0) |=> PARAM_SEL == $past(PARAM_SEL) - 4'h1)
    else $error("down did not select previous parameter");

  AST_ESC_RESUME: assert property (@(posedge CLK) disable iff (RESET)
    (HOLD && press.esc) |=> !HOLD)
    else $error("esc did not resume cycling");

  AST_IDLE_OFF: assert property (@(posedge CLK) disable iff (RESET)
    (BACKLIGHT && !any_press && idle == IW'(IDLE_CYCLES - 1)) |=> !BACKLIGHT)
    else $error("backlight not off after idle timeout");

  AST_KEY_WAKES: assert property (@(posedge CLK) disable iff (RESET)
    any_press |=> (BACKLIGHT && idle == '0))
    else $error("key did not wake backlight or restart timer");

  AST_WAKE_ACTS: assert property (@(posedge CLK) disable iff (RESET)
    (!BACKLIGHT && !HOLD && press.enter) |=> HOLD)
    else $error("waking enter press was not processed");

  sequence s_dwell_end;
    !HOLD && !press.enter && dwell == DW'(DWELL_CYCLES - 1);
  endsequence

  AST_RESET_STATE: assert property (@(posedge CLK)
    RESET |=> (PARAM_SEL == panel_pkg::PARAM_RST && !HOLD && BACKLIGHT))
    else $error("outputs not at reset values");

  AST_CYCLE_WRAP: assert property (@(posedge CLK) disable iff (RESET)
    (s_dwell_end ##0 (PARAM_SEL >= PARAM_LAST)) |=> PARAM_SEL == '0)
    else $error("cycling did not wrap to first parameter");

  AST_UP_WRAP: assert property (@(posedge CLK) disable iff (RESET)
    (HOLD && press.up && !press.esc && PARAM_SEL >= PARAM_LAST) |=> PARAM_SEL == '0)
    else $error("up did not wrap to first parameter");

  AST_DOWN_WRAP: assert property (@(posedge CLK) disable iff (RESET)
    (HOLD && press.down && !press.up && !press.esc && PARAM_SEL == '0) |=> PARAM_SEL == $past(PARAM_LAST))
    else $error("down did not wrap to last parameter");

  AST_ESC_FRESH: assert property (@(posedge CLK) disable iff (RESET)
    (HOLD && press.esc) |=> (dwell == '0 && $stable(PARAM_SEL)))
    else $error("esc did not resume with a fresh dwell");

  AST_LIGHT_STAYS: assert property (@(posedge CLK) disable iff (RESET)
    (BACKLIGHT && !any_press && idle != IW'(IDLE_CYCLES - 1)) |=> BACKLIGHT)
    else $error("backlight went off before idle timeout");

  AST_DARK_STAYS: assert property (@(posedge CLK) disable iff (RESET)
    (!BACKLIGHT && !any_press) |=> !BACKLIGHT)
    else $error("backlight came on without a key");

endmodule : front_panel

`default_nettype wire

//--- test/key_panel.sv
`timescale 1ns/1ps
`default_nettype none

// Front-panel keys: each new press bounces once before settling
module key_panel (
  input  wire logic             CLK,
  input  wire panel_pkg::keys_t want,
  output var  panel_pkg::keys_t KEYS
);
  logic [3:0]       p1;
  logic [3:0]       p2;
  panel_pkg::keys_t w;

  initial
  begin
    KEYS = '0;
    p1   = '0;
    p2   = '0;
  end

  // Want sampled at the edge, clear of the bench's own updates
  always @(posedge CLK)
  begin
    w = want;
    #10;
    KEYS = panel_pkg::keys_t'(w & ~(p1 & ~p2));
    p2   = p1;
    p1   = w;
  end
endmodule : key_panel

`default_nettype wire

//--- test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  localparam int unsigned DWELL = 20;
  localparam logic [3:0]  LAST  = 4'h2;
  logic             CLK;
  logic             RESET;
  panel_pkg::keys_t want;
  panel_pkg::keys_t keys;
  logic [3:0]       sel;
  logic             hold;
  logic             light;
  int               fail_count;
  int               num_checks;
  int               n;
  logic [3:0]       v;

  front_panel #(.DWELL_CYCLES(DWELL), .IDLE_CYCLES(200), .DEBOUNCE_CYCLES(3)) dut (
    .CLK(CLK), .RESET(RESET), .KEYS(keys), .PARAM_LAST(LAST),
    .PARAM_SEL(sel), .HOLD(hold), .BACKLIGHT(light));
  key_panel panel (.CLK(CLK), .want(want), .KEYS(keys));

  initial CLK = 1'b0;
  always #50 CLK = ~CLK;

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  task automatic cycles(input int c);
    repeat (c) @(posedge CLK);
    #10;
  endtask : cycles

  task automatic tap(input int k);
    want[k] = 1'b1;
    cycles(20);
    want[k] = 1'b0;
    cycles(10);
  endtask : tap

  // Cycles until the shown parameter changes
  task automatic dwell();
    v = sel;
    n = 0;
    while (sel === v && n < 100)
    begin
      cycles(1);
      n++;
    end
  endtask : dwell

  function automatic logic [3:0] step(input logic [3:0] x, input logic up);
    if (up)
      return (x == LAST) ? 4'h0 : x + 4'h1;
    return (x == 4'h0) ? LAST : x - 4'h1;
  endfunction : step

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop

  task automatic test_cycle();
    check("sel", sel, 4'h0);
    check("hold", hold, 1'b0);
    check("light", light, 1'b1);
    dwell();
    repeat (4)
    begin
      dwell();
      check("dwell", n, DWELL);
      check("next", sel, step(v, 1'b1));
    end
    $display("test_cycle done");
  endtask : test_cycle

  task automatic test_enter();
    tap(panel_pkg::KEY_UP);
    tap(panel_pkg::KEY_DOWN);
    tap(panel_pkg::KEY_ESC);
    check("hold", hold, 1'b0);
    tap(panel_pkg::KEY_ENTER);
    check("hold", hold, 1'b1);
    v = sel;
    cycles(3 * DWELL);
    check("frozen", sel, v);
    $display("test_enter done");
  endtask : test_enter

  task automatic test_hold();
    for (int i = 0; i < 6; i++)
    begin
      v = sel;
      tap(i < 3 ? panel_pkg::KEY_UP : panel_pkg::KEY_DOWN);
      check("step", sel, step(v, i < 3));
    end
    tap(panel_pkg::KEY_ESC);
    check("hold", hold, 1'b0);
    dwell();
    check("resume", sel, step(v, 1'b1));
    $display("test_hold done");
  endtask : test_hold

  task automatic test_light();
    tap(panel_pkg::KEY_ENTER);
    cycles(150);
    check("light", light, 1'b1);
    cycles(60);
    check("light", light, 1'b0);
    v = sel;
    tap(panel_pkg::KEY_UP);
    check("light", light, 1'b1);
    check("wake", sel, step(v, 1'b1));
    tap(panel_pkg::KEY_ESC);
    check("hold", hold, 1'b0);
    cycles(190);
    check("light", light, 1'b0);
    tap(panel_pkg::KEY_ENTER);
    check("light", light, 1'b1);
    check("wake", hold, 1'b1);
    $display("test_light done");
  endtask : test_light

  initial
  begin
    want = '0;
    RESET = 1'b1;
    fail_count = 0;
    num_checks = 0;
    cycles(4);
    RESET = 1'b0;
    test_cycle();
    test_enter();
    test_hold();
    test_light();
    report_and_stop();
  end

  initial
  begin
    cycles(3000);
    fail_count++;
    report_and_stop();
  end
endmodule : tb_top

`default_nettype wire
